// ---- inc/pdmc_pkg.sv ----
/*
  shared constants, types and lookup functions of the pen digitizer mode control.
  assumes one 125 MHz system clock and a host that reaches the registers over avalon-mm.
*/
package pdmc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets and field positions
  localparam logic [4:0] PDMC_OFS_STATUS = 5'h00;
  localparam logic [4:0] PDMC_OFS_CTRL   = 5'h04;
  localparam logic [4:0] PDMC_OFS_RES    = 5'h08;
  localparam logic [4:0] PDMC_OFS_BAUD   = 5'h0c;
  localparam logic [4:0] PDMC_OFS_COORD  = 5'h10;
  localparam int PDMC_CTRL_PAR_BIT = 0;
  localparam int PDMC_RES_X_LSB    = 0;
  localparam int PDMC_RES_Y_LSB    = 4;
  localparam int PDMC_COORD_Y_LSB  = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // command opcodes (upper nibble of a received byte) and answers
  localparam logic [3:0] PDMC_OP_INIT  = 4'h1;
  localparam logic [3:0] PDMC_OP_SLEEP = 4'h2;
  localparam logic [3:0] PDMC_OP_CAL   = 4'h3;
  localparam logic [3:0] PDMC_OP_SETX  = 4'h4;
  localparam logic [3:0] PDMC_OP_SETY  = 4'h5;
  localparam logic [3:0] PDMC_OP_BAUD  = 4'h6;
  localparam logic [7:0] PDMC_RSP_ACK  = 8'h06;
  localparam logic [7:0] PDMC_RSP_NAK  = 8'h15;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and rates
  localparam logic [2:0] PDMC_RES_IDX_DEF = 3'h6;
  localparam logic [2:0] PDMC_BAUD_IDX_MAX = 3'h5;
  localparam int PDMC_CLK_HZ   = 125_000_000;
  localparam int PDMC_BAUD_300  = 300;
  localparam int PDMC_BAUD_1200 = 1200;
  localparam int PDMC_BAUD_2400 = 2400;
  localparam int PDMC_BAUD_4800 = 4800;
  localparam int PDMC_BAUD_7200 = 7200;
  localparam int PDMC_BAUD_9600 = 9600;
  localparam int PDMC_FIFO_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {PDMC_SLEEP, PDMC_IDLE, PDMC_CMD, PDMC_DATA} pdmc_mode_e;
  typedef enum logic [1:0] {PDMC_SC_X, PDMC_SC_Y, PDMC_SC_PUSH} pdmc_scan_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } pdmc_avs_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } pdmc_avs_rsp_s;

  typedef struct packed {
    logic dtr;
    logic rts;
    logic serial_rx_in;
  } pdmc_link_s;

  typedef struct packed {
    logic       pen_down;
    logic       adc_valid;
    logic [9:0] adc_data;
  } pdmc_panel_s;

  ////////////////////////////////////////////////////////////////////////////////
  // resolution table: one entry per supported x/y pair
  function automatic logic [10:0] pdmc_res_x(input logic [2:0] idx);
    case (idx)
      3'h0:    pdmc_res_x = 11'h100;
      3'h1,
      3'h2:    pdmc_res_x = 11'h140;
      3'h7:    pdmc_res_x = 11'h400;
      default: pdmc_res_x = 11'h280;
    endcase
  endfunction : pdmc_res_x

  function automatic logic [10:0] pdmc_res_y(input logic [2:0] idx);
    case (idx)
      3'h0:    pdmc_res_y = 11'h080;
      3'h1:    pdmc_res_y = 11'h0c8;
      3'h3:    pdmc_res_y = 11'h190;
      3'h4:    pdmc_res_y = 11'h140;
      3'h5:    pdmc_res_y = 11'h1e0;
      3'h7:    pdmc_res_y = 11'h400;
      default: pdmc_res_y = 11'h100;
    endcase
  endfunction : pdmc_res_y

endpackage : pdmc_pkg

// ---- hdl/pdmc_top.sv ----
/*
  pen digitizer mode control: sleep/idle/command/data modes, uart link, panel scan,
  parallel output, a small output fifo and an avalon-mm register slave.
  assumes all inputs synchronous to clk_sys_i and an analog front end that answers a
  raised axis strobe with one adc_valid pulse.
*/

////////////////////////////////////////////////////////////////////////////////
module pdmc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } pdmc_fifo_s;

  pdmc_fifo_s s_reg;
  pdmc_fifo_s s_next;
  logic       push;
  logic       pop;

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
    wrap = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction : wrap

  assign in_ready_o  = (s_reg.cnt != CW'(D));
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o  = s_reg.mem[s_reg.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data_i;
      s_next.wp            = wrap(s_reg.wp);
    end
    if (pop) begin
      s_next.rp = wrap(s_reg.rp);
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : pdmc_fifo

////////////////////////////////////////////////////////////////////////////////
module pdmc_top #(
  parameter int CLK_HZ     = pdmc_pkg::PDMC_CLK_HZ,
  parameter int FIFO_DEPTH = pdmc_pkg::PDMC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  // register bus
  input  wire pdmc_pkg::pdmc_avs_req_s avs_i,
  output pdmc_pkg::pdmc_avs_rsp_s      avs_o,
  // host serial link and handshake
  input  wire pdmc_pkg::pdmc_link_s    link_i,
  output logic                         serial_tx_out_o,
  // jumpers
  input  wire logic [2:0]              jmp_baud_i,
  input  wire logic                    jmp_par_i,
  // panel front end
  input  wire pdmc_pkg::pdmc_panel_s   panel_i,
  output logic                         ctl_x_o,
  output logic                         ctl_y_o,
  // parallel output
  output logic [7:0]                   par_data_o,
  output logic                         par_valid_o,
  input  wire logic                    par_ready_i,
  // mode seen by the system
  output pdmc_pkg::pdmc_mode_e         mode_o
);
  import pdmc_pkg::*;

  typedef struct packed {
    pdmc_mode_e  mode;
    pdmc_scan_e  scan_st;
    logic        strap_done;
    logic [2:0]  jmp_baud;
    logic        par_mode;
    logic [2:0]  baud_idx;
    logic [2:0]  baud_new;
    logic        baud_chg;
    logic [2:0]  res_x_idx;
    logic [2:0]  res_y_idx;
    logic        cal_done;
    logic        bus_ack;
    logic [31:0] rdata;
    logic        rx_busy;
    logic [23:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic        tx_busy;
    logic        tx_rsp;
    logic [23:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_shift;
    logic        rsp_pend;
    logic [7:0]  rsp_byte;
    logic        sleep_after;
    logic [1:0]  push_idx;
    logic [10:0] x_coord;
    logic [10:0] y_coord;
    logic [7:0]  par_data;
    logic        par_valid;
  } pdmc_state_s;

  pdmc_state_s s_reg;
  pdmc_state_s s_next;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [7:0]  f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [7:0]  f_out_data;
  logic        bus_req;
  logic [23:0] bit_len;

  // cycles per serial bit less one, rounded down
  function automatic logic [23:0] bit_cycles(input logic [2:0] idx);
    case (idx)
      3'h0:    bit_cycles = 24'(CLK_HZ / PDMC_BAUD_300);
      3'h1:    bit_cycles = 24'(CLK_HZ / PDMC_BAUD_1200);
      3'h2:    bit_cycles = 24'(CLK_HZ / PDMC_BAUD_2400);
      3'h3:    bit_cycles = 24'(CLK_HZ / PDMC_BAUD_4800);
      3'h4:    bit_cycles = 24'(CLK_HZ / PDMC_BAUD_7200);
      default: bit_cycles = 24'(CLK_HZ / PDMC_BAUD_9600);
    endcase
  endfunction : bit_cycles

  // sample scaled to the axis resolution
  function automatic logic [10:0] scale(input logic [9:0] adc, input logic [10:0] res);
    logic [20:0] prod;
    prod  = 21'(adc) * 21'(res);
    scale = prod[20:10];
  endfunction : scale

  ////////////////////////////////////////////////////////////////////////////////
  // output fifo: scan to serial or parallel drain
  pdmc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data)
  );

  assign bus_req     = avs_i.read | avs_i.write;
  assign bit_len     = bit_cycles(s_reg.baud_idx);
  // a started pair is finished even after pen up
  assign f_in_valid  = (s_reg.mode == PDMC_DATA) && (s_reg.scan_st == PDMC_SC_PUSH)
                       && (panel_i.pen_down || s_reg.push_idx != 2'h0);
  // a response byte always goes before queued coordinates
  assign f_out_ready = (s_reg.mode == PDMC_DATA) && (s_reg.par_mode
                       ? (!s_reg.par_valid || par_ready_i)
                       : (!s_reg.tx_busy && !s_reg.rsp_pend));
  always_comb begin
    case (s_reg.push_idx)
      2'h0:    f_in_data = {5'h00, s_reg.x_coord[10:8]};
      2'h1:    f_in_data = s_reg.x_coord[7:0];
      2'h2:    f_in_data = {5'h00, s_reg.y_coord[10:8]};
      default: f_in_data = s_reg.y_coord[7:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    // jumpers latched on the first clock after reset
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.jmp_baud   = (jmp_baud_i > PDMC_BAUD_IDX_MAX) ? PDMC_BAUD_IDX_MAX : jmp_baud_i;
      s_next.baud_idx   = s_next.jmp_baud;
      s_next.par_mode   = jmp_par_i;
    end

    // bus slave: one wait cycle
    s_next.bus_ack = bus_req & ~s_reg.bus_ack;
    if (bus_req && !s_reg.bus_ack) begin
      case (avs_i.address)
        PDMC_OFS_STATUS: s_next.rdata = {27'h0, s_reg.cal_done, s_reg.tx_busy,
                                         s_reg.rx_busy, s_reg.mode};
        PDMC_OFS_CTRL:   s_next.rdata = {31'h0, s_reg.par_mode};
        PDMC_OFS_RES:    s_next.rdata = {25'h0, s_reg.res_y_idx, 1'b0, s_reg.res_x_idx};
        PDMC_OFS_BAUD:   s_next.rdata = {29'h0, s_reg.baud_idx};
        PDMC_OFS_COORD:  s_next.rdata = {5'h0, s_reg.y_coord, 5'h0, s_reg.x_coord};
        default:         s_next.rdata = 32'h0;
      endcase
    end
    if (avs_i.write && s_reg.bus_ack) begin
      case (avs_i.address)
        PDMC_OFS_CTRL: s_next.par_mode = avs_i.writedata[PDMC_CTRL_PAR_BIT];
        PDMC_OFS_RES: begin
          s_next.res_x_idx = avs_i.writedata[PDMC_RES_X_LSB +: 3];
          s_next.res_y_idx = avs_i.writedata[PDMC_RES_Y_LSB +: 3];
        end
        PDMC_OFS_BAUD: begin
          if (avs_i.writedata[2:0] <= PDMC_BAUD_IDX_MAX) begin
            s_next.baud_idx = avs_i.writedata[2:0];
          end
        end
        default: ;
      endcase
    end

    // serial receiver, only listening in command mode
    if (!s_reg.rx_busy) begin
      if (s_reg.mode == PDMC_CMD && !link_i.serial_rx_in) begin
        s_next.rx_busy = 1'b1;
        s_next.rx_bit  = 4'h0;
        s_next.rx_cnt  = {1'b0, bit_len[23:1]};
      end
    end else if (s_reg.rx_cnt != 24'h0) begin
      s_next.rx_cnt = s_reg.rx_cnt - 24'h1;
    end else begin
      s_next.rx_cnt = bit_len;
      s_next.rx_bit = s_reg.rx_bit + 4'h1;
      if (s_reg.rx_bit == 4'h0 && link_i.serial_rx_in) begin
        s_next.rx_busy = 1'b0; // glitch, not a start bit
      end else if (s_reg.rx_bit != 4'h0 && s_reg.rx_bit < 4'h9) begin
        s_next.rx_shift = {link_i.serial_rx_in, s_reg.rx_shift[7:1]};
      end else if (s_reg.rx_bit == 4'h9) begin
        s_next.rx_busy = 1'b0;
        // bad stop bit: dropped, no answer
        if (link_i.serial_rx_in && s_reg.mode == PDMC_CMD && !s_reg.rsp_pend
            && !s_reg.tx_rsp) begin
          s_next.rsp_pend = 1'b1;
          s_next.rsp_byte = PDMC_RSP_ACK;
          case (s_reg.rx_shift[7:4])
            PDMC_OP_INIT: begin
              s_next.res_x_idx = PDMC_RES_IDX_DEF;
              s_next.res_y_idx = PDMC_RES_IDX_DEF;
              s_next.baud_new  = s_reg.jmp_baud;
              s_next.baud_chg  = 1'b1;
              s_next.cal_done  = 1'b0;
            end
            PDMC_OP_SLEEP: s_next.sleep_after = 1'b1;
            PDMC_OP_CAL:   s_next.cal_done = 1'b1;
            PDMC_OP_SETX:  s_next.res_x_idx = s_reg.rx_shift[2:0];
            PDMC_OP_SETY:  s_next.res_y_idx = s_reg.rx_shift[2:0];
            PDMC_OP_BAUD: begin
              if (s_reg.rx_shift[2:0] <= PDMC_BAUD_IDX_MAX) begin
                s_next.baud_new = s_reg.rx_shift[2:0];
                s_next.baud_chg = 1'b1;
              end else begin
                s_next.rsp_byte = PDMC_RSP_NAK;
              end
            end
            default: s_next.rsp_byte = PDMC_RSP_NAK;
          endcase
        end
      end
    end

    // transmitter: answer first, else fifo bytes
    if (!s_reg.tx_busy) begin
      if (s_reg.rsp_pend) begin
        s_next.tx_busy  = 1'b1;
        s_next.tx_rsp   = 1'b1;
        s_next.rsp_pend = 1'b0;
        s_next.tx_shift = {1'b1, s_reg.rsp_byte, 1'b0};
        s_next.tx_bit   = 4'h0;
        s_next.tx_cnt   = bit_len;
      end else if (f_out_valid && f_out_ready && !s_reg.par_mode) begin
        s_next.tx_busy  = 1'b1;
        s_next.tx_shift = {1'b1, f_out_data, 1'b0};
        s_next.tx_bit   = 4'h0;
        s_next.tx_cnt   = bit_len;
      end
    end else if (s_reg.tx_cnt != 24'h0) begin
      s_next.tx_cnt = s_reg.tx_cnt - 24'h1;
    end else begin
      s_next.tx_cnt   = bit_len;
      s_next.tx_shift = {1'b1, s_reg.tx_shift[9:1]};
      s_next.tx_bit   = s_reg.tx_bit + 4'h1;
      if (s_reg.tx_bit == 4'h9) begin
        s_next.tx_busy = 1'b0;
        s_next.tx_rsp  = 1'b0;
      end
    end

    // parallel drain: byte register with valid/ready
    if (s_reg.par_valid && par_ready_i) begin
      s_next.par_valid = 1'b0;
    end
    if (f_out_valid && f_out_ready && s_reg.par_mode) begin
      s_next.par_data  = f_out_data;
      s_next.par_valid = 1'b1;
    end

    // panel scan: x, y, then the pair's four bytes
    if (s_reg.mode == PDMC_DATA) begin
      case (s_reg.scan_st)
        PDMC_SC_X: begin
          if (panel_i.adc_valid) begin
            s_next.x_coord = scale(panel_i.adc_data, pdmc_res_x(s_reg.res_x_idx));
            s_next.scan_st = PDMC_SC_Y;
          end
        end
        PDMC_SC_Y: begin
          if (panel_i.adc_valid) begin
            s_next.y_coord = scale(panel_i.adc_data, pdmc_res_y(s_reg.res_y_idx));
            s_next.scan_st = PDMC_SC_PUSH;
            s_next.push_idx = 2'h0;
          end
        end
        PDMC_SC_PUSH: begin
          if (!panel_i.pen_down && s_reg.push_idx == 2'h0) begin
            s_next.scan_st = PDMC_SC_X;
          end else if (f_in_ready) begin
            s_next.push_idx = s_reg.push_idx + 2'h1;
            if (s_reg.push_idx == 2'h3) begin
              s_next.scan_st = PDMC_SC_X;
            end
          end
        end
        default: s_next.scan_st = PDMC_SC_X;
      endcase
    end else begin
      s_next.scan_st = PDMC_SC_X;
    end

    // mode control
    case (s_reg.mode)
      PDMC_SLEEP: begin
        if (link_i.dtr || link_i.rts || !link_i.serial_rx_in) begin
          s_next.mode = PDMC_IDLE;
        end
      end
      PDMC_IDLE: begin
        if (link_i.dtr) begin
          s_next.mode = PDMC_CMD;
        end else if (link_i.rts) begin
          s_next.mode = PDMC_DATA;
        end
      end
      PDMC_CMD: begin
        // leave when the answer's stop bit ends
        if (s_reg.tx_rsp && s_reg.tx_busy && s_reg.tx_bit == 4'h9 && s_reg.tx_cnt == 24'h0) begin
          s_next.mode        = s_reg.sleep_after ? PDMC_SLEEP : PDMC_IDLE;
          s_next.sleep_after = 1'b0;
          if (s_reg.baud_chg) begin
            s_next.baud_idx = s_reg.baud_new;
            s_next.baud_chg = 1'b0;
          end
        end
      end
      PDMC_DATA: begin
        if (link_i.dtr) begin
          s_next.mode = PDMC_CMD;
        end else if (!link_i.rts) begin
          s_next.mode = PDMC_IDLE;
        end
      end
      default: s_next.mode = PDMC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg           <= '0;
      s_reg.mode      <= PDMC_IDLE;
      s_reg.scan_st   <= PDMC_SC_X;
      s_reg.res_x_idx <= PDMC_RES_IDX_DEF;
      s_reg.res_y_idx <= PDMC_RES_IDX_DEF;
      s_reg.tx_shift  <= 10'h3ff;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_o.readdata    = s_reg.rdata;
  assign avs_o.waitrequest = bus_req & ~s_reg.bus_ack;
  assign serial_tx_out_o   = s_reg.tx_busy ? s_reg.tx_shift[0] : 1'b1;
  assign ctl_x_o           = (s_reg.mode == PDMC_DATA) && (s_reg.scan_st == PDMC_SC_X);
  assign ctl_y_o           = (s_reg.mode == PDMC_DATA) && (s_reg.scan_st == PDMC_SC_Y);
  assign par_data_o        = s_reg.par_data;
  assign par_valid_o       = s_reg.par_valid;
  assign mode_o            = s_reg.mode;
endmodule : pdmc_top

// ---- bench/pdmc_top_assertions.sv ----
/* assertions on the pdmc_top ports: modes, scan order and handshakes.
   assumes a bind into pdmc_top. */
module pdmc_top_assertions
  import pdmc_pkg::*;
#(
  parameter int CLK_HZ     = PDMC_CLK_HZ,
  parameter int FIFO_DEPTH = PDMC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic                    clk_sys_i,
  input wire logic                    rst_n_i,
  // watched ports
  input wire pdmc_pkg::pdmc_avs_req_s avs_i,
  input wire pdmc_pkg::pdmc_avs_rsp_s avs_o,
  input wire pdmc_pkg::pdmc_link_s    link_i,
  input wire pdmc_pkg::pdmc_panel_s   panel_i,
  input wire logic                    serial_tx_out_o,
  input wire logic                    ctl_x_o,
  input wire logic                    ctl_y_o,
  input wire logic [7:0]              par_data_o,
  input wire logic                    par_valid_o,
  input wire logic                    par_ready_i,
  input wire pdmc_pkg::pdmc_mode_e    mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // link steady, so no mode change excuses it
  sequence s_x_done;
    ctl_x_o && panel_i.adc_valid && mode_o == PDMC_DATA && link_i.rts && !link_i.dtr;
  endsequence
  sequence s_wake;
    mode_o == PDMC_SLEEP && (link_i.dtr || link_i.rts || !link_i.serial_rx_in);
  endsequence
  ////////////////////////////////////////
  AST_BUS_WAIT: assert property (
    (avs_i.read || avs_i.write) && avs_o.waitrequest |=> !avs_o.waitrequest)
    else $error("bus answer late");
  AST_X_THEN_Y: assert property (s_x_done |=> ctl_y_o)
    else $error("y cycle missing");
  AST_XY_EXCL: assert property (!(ctl_x_o && ctl_y_o))
    else $error("both axes driven");
  AST_SCAN_DATA: assert property ((ctl_x_o || ctl_y_o) |-> mode_o == PDMC_DATA)
    else $error("scan out of mode");
  AST_WAKE: assert property (s_wake |=> mode_o == PDMC_IDLE)
    else $error("no wake from halt");
  AST_SLEEP_TX: assert property (mode_o == PDMC_SLEEP |-> serial_tx_out_o)
    else $error("sent in halt");
  AST_DTR_CMD: assert property (
    (mode_o == PDMC_IDLE || mode_o == PDMC_DATA) && link_i.dtr |=> mode_o == PDMC_CMD)
    else $error("dtr ignored");
  AST_CMD_HOLD: assert property (
    mode_o == PDMC_CMD && !serial_tx_out_o |=> mode_o == PDMC_CMD)
    else $error("left mid reply");
  AST_RTS_DATA: assert property (
    mode_o == PDMC_IDLE && link_i.rts && !link_i.dtr |=> mode_o == PDMC_DATA)
    else $error("rts ignored");
  AST_PAR_HOLD: assert property (
    par_valid_o && !par_ready_i |=> par_valid_o && $stable(par_data_o))
    else $error("byte dropped");
endmodule : pdmc_top_assertions

bind pdmc_top pdmc_top_assertions #(.CLK_HZ(CLK_HZ), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_i(avs_i), .avs_o(avs_o),
  .link_i(link_i), .panel_i(panel_i), .serial_tx_out_o(serial_tx_out_o),
  .ctl_x_o(ctl_x_o), .ctl_y_o(ctl_y_o), .par_data_o(par_data_o),
  .par_valid_o(par_valid_o), .par_ready_i(par_ready_i), .mode_o(mode_o));

// ---- bench/pdmc_host_model.sv ----
/* host serial port model: 8n1 sender and receiver at a fixed bit time.
   assumes the device line idles high and runs at the same rate. */
module pdmc_host_model #(
  parameter int BIT_CYC = 11
) (
  // clock
  input  wire logic clk_sys_i,
  // serial lines
  input  wire logic tx_i,
  output logic      rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial rx_o = 1'b1;
  ////////////////////////////////////////
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys_i);
      rx_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_sys_i);
    end
  endtask : send_byte
  // a bare low pulse wakes a halted device
  task automatic line_low;
    @(posedge clk_sys_i);
    rx_o <= 1'b0;
    @(posedge clk_sys_i);
    rx_o <= 1'b1;
  endtask : line_low
  ////////////////////////////////////////
  always begin
    @(negedge tx_i);
    repeat (BIT_CYC / 2) @(posedge clk_sys_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys_i);
      sh[i] = tx_i;
    end
    repeat (BIT_CYC) @(posedge clk_sys_i);
    rx_q.push_back(sh);
  end
endmodule : pdmc_host_model

// ---- bench/pdmc_top_tb.sv ----
/* bench for pdmc_top: registers, commands, serial and parallel data, halt.
   assumes pdmc_host_model on the link and a shortened CLK_HZ. */
module pdmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pdmc_pkg::*;
  // 9600 baud: 11 cycles a bit
  localparam int HZ = 96000;
  localparam int XV = 512 * 640 / 1024;
  localparam int YV = 256 * 256 / 1024;
  logic          clk_sys_i = 1'b0;
  logic          rst_n_i   = 1'b0;
  pdmc_avs_req_s avs_req   = '0;
  pdmc_avs_rsp_s avs_rsp;
  logic          dtr = 1'b0, rts = 1'b0, pen = 1'b0, rdy = 1'b0, adc_v = 1'b0;
  logic [9:0]    adc_d = '0;
  logic [2:0]    cnt   = '0;
  logic          host_rx, tx, ctl_x, ctl_y, par_v;
  logic [7:0]    par_d;
  logic [7:0]    par_q[$];
  logic [7:0]    pat[4] = '{8'(XV >> 8), 8'(XV), 8'(YV >> 8), 8'(YV)};
  pdmc_mode_e    mode;
  pdmc_link_s    link;
  pdmc_panel_s   panel;
  int            n_errors = 0, check_count = 0;
  assign link  = '{dtr, rts, host_rx};
  assign panel = '{pen, adc_v, adc_d};
  always #4 clk_sys_i = ~clk_sys_i;
  pdmc_top #(.CLK_HZ(HZ), .FIFO_DEPTH(PDMC_FIFO_DEPTH)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_i(avs_req), .avs_o(avs_rsp),
    .link_i(link), .serial_tx_out_o(tx), .jmp_baud_i(3'h7), .jmp_par_i(1'b1),
    .panel_i(panel), .ctl_x_o(ctl_x), .ctl_y_o(ctl_y), .par_data_o(par_d),
    .par_valid_o(par_v), .par_ready_i(rdy), .mode_o(mode));
  pdmc_host_model #(.BIT_CYC(HZ / 9600 + 1)) i_host (
    .clk_sys_i(clk_sys_i), .tx_i(tx), .rx_o(host_rx));
  ////////////////////////////////////////
  // front end: one adc pulse per axis strobe
  always @(posedge clk_sys_i) begin
    adc_v <= 1'b0;
    if ((ctl_x || ctl_y) && !adc_v) begin
      cnt <= cnt + 3'h1;
      if (cnt == 3'h3) begin
        adc_v <= 1'b1;
        adc_d <= ctl_x ? 10'h200 : 10'h100;
        cnt   <= '0;
      end
    end
    if (par_v && rdy) begin
      par_q.push_back(par_d);
    end
  end
  ////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_req <= '{read: ~wr, write: wr, address: a, writedata: wd};
    do begin
      @(posedge clk_sys_i);
    end while (avs_rsp.waitrequest !== 1'b0);
    rd = avs_rsp.readdata;
    avs_req <= '0;
    @(posedge clk_sys_i);
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, '0, d);
    chk(d, e);
  endtask : rchk
  task automatic wait_mode(input pdmc_mode_e m);
    for (int t = 0; t < 400 && mode !== m; t++) @(posedge clk_sys_i);
    chk(mode, m);
  endtask : wait_mode
  task automatic cmd(input logic [7:0] c, input logic [7:0] r, input pdmc_mode_e m);
    dtr <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    dtr <= 1'b0;
    chk(mode, PDMC_CMD);
    i_host.send_byte(c);
    for (int t = 0; t < 400 && i_host.rx_q.size() == 0; t++) @(posedge clk_sys_i);
    chk(i_host.rx_q.size(), 1);
    chk(i_host.rx_q[0], r);
    i_host.rx_q.delete();
    wait_mode(m);
  endtask : cmd
  // pen up must not split a frame
  task automatic frames(input bit par);
    int k;
    k = 0;
    pen <= 1'b1;
    rts <= 1'b1;
    if (par) begin
      repeat (300) @(posedge clk_sys_i);
      chk(par_v, 1'b1);
      chk(par_q.size(), 0);
      rdy <= 1'b1;
    end
    for (int t = 0; t < 5000 && (par ? par_q.size() : i_host.rx_q.size()) < 8; t++)
      @(posedge clk_sys_i);
    chk(mode, PDMC_DATA);
    pen <= 1'b0;
    for (int t = 0; t < 4000 && k < 300; t++) begin
      @(posedge clk_sys_i);
      k = (par ? !par_v : tx) ? k + 1 : 0;
    end
    if (par) chk(i_host.rx_q.size(), 0);
    if (par) chk_q(par_q); else chk_q(i_host.rx_q);
  endtask : frames
  task automatic chk_q(ref logic [7:0] q[$]);
    chk(q.size() >= 8 && q.size() % 4 == 0, 1'b1);
    for (int i = 0; i < q.size(); i++) chk(q[i], pat[i % 4]);
    q.delete();
  endtask : chk_q
  ////////////////////////////////////////
  task automatic t_regs;
    rchk(PDMC_OFS_STATUS, 32'h1);
    rchk(PDMC_OFS_RES, 32'h66);
    rchk(PDMC_OFS_BAUD, 32'h5);
    rchk(PDMC_OFS_CTRL, 32'h1);
    wr(PDMC_OFS_CTRL, 32'h0);
    rchk(5'h14, 32'h0);
    wr(PDMC_OFS_STATUS, 32'hff);
    rchk(PDMC_OFS_STATUS, 32'h1);
    wr(PDMC_OFS_BAUD, 32'h7);
    rchk(PDMC_OFS_BAUD, 32'h5);
    wr(PDMC_OFS_RES, 32'h77);
    rchk(PDMC_OFS_RES, 32'h77);
    wr(PDMC_OFS_RES, 32'h66);
  endtask : t_regs
  task automatic t_cmds;
    cmd(8'h47, PDMC_RSP_ACK, PDMC_IDLE);
    rchk(PDMC_OFS_RES, 32'h67);
    cmd(8'h53, PDMC_RSP_ACK, PDMC_IDLE);
    rchk(PDMC_OFS_RES, 32'h37);
    cmd(8'h67, PDMC_RSP_NAK, PDMC_IDLE);
    cmd(8'h90, PDMC_RSP_NAK, PDMC_IDLE);
    cmd(8'h30, PDMC_RSP_ACK, PDMC_IDLE);
    rchk(PDMC_OFS_STATUS, 32'h11);
    cmd(8'h10, PDMC_RSP_ACK, PDMC_IDLE);
    rchk(PDMC_OFS_RES, 32'h66);
    rchk(PDMC_OFS_STATUS, 32'h1);
    cmd(8'h65, PDMC_RSP_ACK, PDMC_IDLE);
    rchk(PDMC_OFS_BAUD, 32'h5);
  endtask : t_cmds
  task automatic t_sleep;
    pen <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      cmd(8'h20, PDMC_RSP_ACK, PDMC_SLEEP);
      repeat (100) @(posedge clk_sys_i);
      chk(mode, PDMC_SLEEP);
      chk(i_host.rx_q.size(), 0);
      rts <= (s == 0);
      dtr <= (s == 2);
      if (s == 1) i_host.line_low(); else @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      chk(mode, PDMC_IDLE);
      rts <= 1'b0;
    end
    pen <= 1'b0;
    cmd(8'h10, PDMC_RSP_ACK, PDMC_IDLE);
  endtask : t_sleep
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(mode, PDMC_IDLE);
    t_regs;
    t_cmds;
    frames(1'b0);
    cmd(8'h30, PDMC_RSP_ACK, PDMC_DATA);
    rts <= 1'b0;
    wait_mode(PDMC_IDLE);
    wr(PDMC_OFS_CTRL, 32'h1);
    rchk(PDMC_OFS_CTRL, 32'h1);
    frames(1'b1);
    rts <= 1'b0;
    rdy <= 1'b0;
    wait_mode(PDMC_IDLE);
    wr(PDMC_OFS_CTRL, 32'h0);
    t_sleep;
    final_report;
  end
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    n_errors++;
    final_report;
  end
endmodule : pdmc_top_tb
